// *** src/baud_lin_ctrl.sv ***
// Baud divider chain and LIN break length control with an APB register slave
// Operation
// - With master break enable set a requested break lasts 13 bit times (8-bit) or 14 (9-bit).
// - With slave break detect enable set a break is seen only after 11 or 12 low bit times.
// - Detection filters an all-zero character and software still checks the break length.
// - The coarse select codes 00..11 divide by 1, 3, 4 or 13, reset giving 1.
// - The rate select divides by two to the power of its code, reset giving 1.
// - Fine select 000 bypasses the fine prescaler and codes 1..7 divide by code plus one.
// - The bypass code also disables clock insertion.
// - The insertion count adds that many extra clocks per 32 fine prescaler outputs.
// - Bit rate is source over 64 times coarse times rate times fine plus fraction.
// - One divider chain sets the common rate for receiver and transmitter.
// - A configuration bit selects the bus clock or the oscillator clock as source.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module baud_lin_ctrl (
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        OSC_CLK_IN,
    input  wire logic        RXD_IN,
    input  wire logic        BREAK_REQ_IN,
    output logic             SAMPLE_TICK_OUT,
    output logic             BIT_TICK_OUT,
    output logic             BREAK_TX_OUT,
    output logic             BREAK_DONE_OUT,
    output logic             BREAK_DETECT_OUT
);
    import baud_lin_pkg::*;

    typedef enum logic {TX_IDLE, TX_BREAK} tx_state_t;

    rate_ctrl_t rate_q;
    fine_ctrl_t fine_q;
    cfg_t       cfg_q;
    tx_state_t  tx_state_q;
    logic       osc_s1_q, osc_s2_q, osc_s3_q, rx_s1_q, rx_s2_q, insert_q, armed_q;
    logic [1:0] samp_cnt_q;
    logic [2:0] fine_cnt_q, fine_last;
    logic [3:0] coarse_cnt_q, bit_cnt_q, tx_cnt_q, low_cnt_q, tx_len, rx_len;
    logic [4:0] acc_q, slot_q, ins_seen_q;
    logic [5:0] acc_sum;
    logic [6:0] rate_cnt_q, rate_mask;
    logic       src_en, fine_tick, coarse_tick, rate_tick, bypass, run, setup, access, wr;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait, ready raised in the cycle after setup
    assign setup  = PSEL_IN && !PENABLE_IN;
    assign access = PSEL_IN && PENABLE_IN && PREADY_OUT;
    assign wr     = access && PWRITE_IN && !PSLVERR_OUT;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0;
        end else begin
            PREADY_OUT  <= setup;
            PSLVERR_OUT <= 1'b0;
            if (setup) begin
                PRDATA_OUT <= 32'h0;
                unique case (PADDR_IN)
                    OFS_RATE: PRDATA_OUT[7:0] <= rate_q;
                    OFS_FINE: PRDATA_OUT[7:0] <= fine_q;
                    OFS_CFG:  PRDATA_OUT[7:0] <= cfg_q;
                    OFS_STAT: PRDATA_OUT[13:0] <= {slot_q, armed_q,
                                                   tx_state_q == TX_BREAK,
                                                   3'h0, low_cnt_q};
                    default:  PSLVERR_OUT <= 1'b1;
                endcase
            end
        end
    end

    // Writes land at the access edge only
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rate_q <= RATE_RST;
            fine_q <= FINE_RST;
            cfg_q  <= CFG_RST;
        end else if (wr) begin
            if (PADDR_IN == OFS_RATE) rate_q <= PWDATA_IN[7:0] & RATE_WMASK;
            if (PADDR_IN == OFS_FINE) fine_q <= PWDATA_IN[7:0];
            if (PADDR_IN == OFS_CFG)  cfg_q  <= PWDATA_IN[7:0] & CFG_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; oscillator must be well below half CLK_IN
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            rx_s1_q  <= 1'b1;
            rx_s2_q  <= 1'b1;
        end else begin
            osc_s1_q <= OSC_CLK_IN;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            rx_s1_q  <= RXD_IN;
            rx_s2_q  <= rx_s1_q;
        end
    end

    assign run    = cfg_q.serial_module_enable;
    assign src_en = run && (cfg_q.serial_clock_source_select ? (osc_s2_q && !osc_s3_q) : 1'b1);

    ////////////////////////////////////////////////////////////////////////
    // Fine prescaler with fractional insertion
    assign bypass    = fine_q.fine_prescaler_select == 3'h0;
    assign fine_last = fine_q.fine_prescaler_select;
    // bypass passes the source straight on
    assign fine_tick = src_en && (bypass || (fine_cnt_q == fine_last && !insert_q));
    assign acc_sum   = {1'b0, acc_q} + {1'b0, fine_q.clock_insertion_count};

    // count to code, one extra when inserting
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            fine_cnt_q <= 3'h0;
            insert_q   <= 1'b0;
        end else if (!run || bypass) begin
            fine_cnt_q <= 3'h0;
            insert_q   <= 1'b0;
        end else if (src_en) begin
            if (fine_cnt_q == fine_last && insert_q) begin
                insert_q <= 1'b0;
            end else if (fine_tick) begin
                fine_cnt_q <= 3'h0;
                // carry of the accumulator spreads the extras
                insert_q   <= acc_sum[5];
            end else begin
                fine_cnt_q <= fine_cnt_q + 3'h1;
            end
        end
    end

    // frame of 32 outputs, accumulator adds the count each output
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            acc_q      <= 5'h0;
            slot_q     <= 5'h0;
            ins_seen_q <= 5'h0;
        end else if (!run || bypass) begin
            // bypass code drops the fine adjust
            acc_q      <= 5'h0;
            slot_q     <= 5'h0;
            ins_seen_q <= 5'h0;
        end else if (fine_tick) begin
            acc_q      <= acc_sum[4:0];
            slot_q     <= slot_q + 5'h1;
            ins_seen_q <= (slot_q == FRAME_LAST) ? 5'h0 : ins_seen_q + {4'h0, acc_sum[5]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Coarse, power-of-two and fixed /64 stages
    // coarse divisor 1, 3, 4, 13
    assign coarse_tick = fine_tick && coarse_cnt_q == coarse_last(rate_q.coarse_prescaler_select);
    assign rate_mask   = 7'((8'h1 << rate_q.rate_select) - 8'h1);
    assign rate_tick   = coarse_tick && ((rate_cnt_q & rate_mask) == rate_mask);

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            coarse_cnt_q <= 4'h0;
        end else if (!run || coarse_tick) begin
            coarse_cnt_q <= 4'h0;
        end else if (fine_tick) begin
            coarse_cnt_q <= coarse_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rate_cnt_q <= 7'h0;
        end else if (!run || rate_tick) begin
            rate_cnt_q <= 7'h0;
        end else if (coarse_tick) begin
            rate_cnt_q <= rate_cnt_q + 7'h1;
        end
    end

    // /4 gives the 16x sample tick, /16 more gives the bit tick
    // the same ticks feed receiver and transmitter
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            samp_cnt_q      <= 2'h0;
            bit_cnt_q       <= 4'h0;
            SAMPLE_TICK_OUT <= 1'b0;
            BIT_TICK_OUT    <= 1'b0;
        end else begin
            SAMPLE_TICK_OUT <= 1'b0;
            BIT_TICK_OUT    <= 1'b0;
            if (!run) begin
                samp_cnt_q <= 2'h0;
                bit_cnt_q  <= 4'h0;
            end else if (rate_tick) begin
                samp_cnt_q <= samp_cnt_q + 2'h1;
                if (samp_cnt_q == SAMPLE_LAST) begin
                    SAMPLE_TICK_OUT <= 1'b1;
                    bit_cnt_q       <= bit_cnt_q + 4'h1;
                    BIT_TICK_OUT    <= bit_cnt_q == BIT_LAST;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break generation; the first bit may be partial, up to one bit short
    // LIN master lengths
    assign tx_len = rate_q.master_break_enable ?
                    (cfg_q.nine_bit_chars ? TX_BRK_LIN9 : TX_BRK_LIN8) :
                    (cfg_q.nine_bit_chars ? TX_BRK_NORM9 : TX_BRK_NORM8);

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tx_state_q     <= TX_IDLE;
            tx_cnt_q       <= 4'h0;
            BREAK_TX_OUT   <= 1'b0;
            BREAK_DONE_OUT <= 1'b0;
        end else begin
            BREAK_DONE_OUT <= 1'b0;
            unique case (tx_state_q)
                TX_IDLE: begin
                    if (BREAK_REQ_IN && run) begin
                        tx_state_q   <= TX_BREAK;
                        tx_cnt_q     <= 4'h0;
                        BREAK_TX_OUT <= 1'b1;
                    end
                end
                TX_BREAK: begin
                    if (!run) begin
                        tx_state_q   <= TX_IDLE;
                        BREAK_TX_OUT <= 1'b0;
                    end else if (BIT_TICK_OUT) begin
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                        if (tx_cnt_q == tx_len - 4'h1) begin
                            tx_state_q     <= TX_IDLE;
                            BREAK_TX_OUT   <= 1'b0;
                            BREAK_DONE_OUT <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break detection, one report per low stretch
    // LIN slave thresholds
    assign rx_len = rate_q.slave_break_detect_enable ?
                    (cfg_q.nine_bit_chars ? RX_BRK_LIN9 : RX_BRK_LIN8) :
                    (cfg_q.nine_bit_chars ? RX_BRK_NORM9 : RX_BRK_NORM8);

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            low_cnt_q        <= 4'h0;
            armed_q          <= 1'b0;
            BREAK_DETECT_OUT <= 1'b0;
        end else begin
            BREAK_DETECT_OUT <= 1'b0;
            if (!run) begin
                low_cnt_q <= 4'h0;
                armed_q   <= 1'b0;
            end else if (BIT_TICK_OUT) begin
                if (rx_s2_q) begin
                    low_cnt_q <= 4'h0;
                    armed_q   <= 1'b1;
                end else begin
                    if (low_cnt_q != 4'hf) low_cnt_q <= low_cnt_q + 4'h1;
                    // a zero character stays below the threshold
                    if (armed_q && low_cnt_q + 4'h1 == rx_len) begin
                        BREAK_DETECT_OUT <= 1'b1;
                        armed_q          <= 1'b0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [3:0] brk_len_q;
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) brk_len_q <= 4'h0;
        else if (!BREAK_TX_OUT) brk_len_q <= 4'h0;
        else if (BIT_TICK_OUT) brk_len_q <= brk_len_q + 4'h1;
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_tx_break_len: assert property (BREAK_DONE_OUT |-> brk_len_q == tx_len)
        else $error("break length wrong");
    a_detect_thresh: assert property ($rose(BREAK_DETECT_OUT) |-> low_cnt_q == rx_len)
        else $error("break detect threshold wrong");
    a_detect_once: assert property (BREAK_DETECT_OUT |=> !armed_q)
        else $error("detector rearmed without idle");
    a_coarse_div: assert property (coarse_tick && run |->
        coarse_cnt_q == coarse_last(rate_q.coarse_prescaler_select))
        else $error("coarse divisor wrong");
    a_rate_div: assert property (rate_tick |-> (rate_cnt_q & rate_mask) == rate_mask)
        else $error("rate divisor wrong");
    a_bypass_pass: assert property (bypass && src_en |-> fine_tick)
        else $error("bypass does not pass source");
    a_bypass_noins: assert property (bypass |=> !insert_q && acc_q == 5'h0)
        else $error("insertion active in bypass");
    a_frame_ins: assert property (fine_tick && slot_q == FRAME_LAST && !bypass
        && $stable(fine_q) |-> ins_seen_q + {4'h0, acc_sum[5]} <= fine_q.clock_insertion_count)
        else $error("too many inserted clocks");
    a_ins_spread: assert property (insert_q && src_en && fine_cnt_q == fine_last
        |=> !insert_q)
        else $error("inserted clocks grouped");
    a_bit_tick: assert property (BIT_TICK_OUT |->
        $past(SAMPLE_TICK_OUT, 1) == 1'b0 && bit_cnt_q == 4'h0)
        else $error("bit tick off the x16 grid");
    a_src_sel: assert property (!run |-> !src_en)
        else $error("source runs while disabled");
    a_apb_ready: assert property (setup |=> PREADY_OUT ##1 !PREADY_OUT)
        else $error("ready timing wrong");

    c_lin_tx: cover property (BREAK_DONE_OUT && rate_q.master_break_enable);
    c_lin_rx: cover property (BREAK_DETECT_OUT && rate_q.slave_break_detect_enable);
    c_insert: cover property (insert_q && fine_q.clock_insertion_count == 5'h1f);
    c_coarse13: cover property (coarse_tick && rate_q.coarse_prescaler_select == 2'h3);
endmodule

// *** src/baud_lin_pkg.sv ***
// Constants, field layouts and helpers for the serial baud and break block
package baud_lin_pkg;
    localparam logic [7:0] OFS_RATE = 8'h00;
    localparam logic [7:0] OFS_FINE = 8'h04;
    localparam logic [7:0] OFS_CFG  = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;

    typedef struct packed {
        logic       master_break_enable;
        logic       slave_break_detect_enable;
        logic [1:0] coarse_prescaler_select;
        logic       rsvd;
        logic [2:0] rate_select;
    } rate_ctrl_t;

    typedef struct packed {
        logic [2:0] fine_prescaler_select;
        logic [4:0] clock_insertion_count;
    } fine_ctrl_t;

    typedef struct packed {
        logic [4:0] rsvd;
        logic       nine_bit_chars;
        logic       serial_module_enable;
        logic       serial_clock_source_select;
    } cfg_t;

    localparam logic [7:0] RATE_RST   = 8'h00;
    localparam logic [7:0] FINE_RST   = 8'h00;
    localparam logic [7:0] CFG_RST    = 8'h00;
    localparam logic [7:0] RATE_WMASK = 8'hf7;
    localparam logic [7:0] CFG_WMASK  = 8'h07;

    // Break lengths in bit times
    localparam logic [3:0] TX_BRK_NORM8 = 4'ha;
    localparam logic [3:0] TX_BRK_NORM9 = 4'hb;
    localparam logic [3:0] TX_BRK_LIN8  = 4'hd;
    localparam logic [3:0] TX_BRK_LIN9  = 4'he;
    localparam logic [3:0] RX_BRK_NORM8 = 4'ha;
    localparam logic [3:0] RX_BRK_NORM9 = 4'hb;
    localparam logic [3:0] RX_BRK_LIN8  = 4'hb;
    localparam logic [3:0] RX_BRK_LIN9  = 4'hc;

    // Fixed /64 = /4 to the sample tick, then /16 to the bit tick
    localparam logic [1:0] SAMPLE_LAST = 2'h3;
    localparam logic [3:0] BIT_LAST    = 4'hf;
    localparam logic [4:0] FRAME_LAST  = 5'h1f;

    function automatic logic [3:0] coarse_last(input logic [1:0] sel);
        case (sel)
            2'h0:    coarse_last = 4'h0;
            2'h1:    coarse_last = 4'h2;
            2'h2:    coarse_last = 4'h3;
            default: coarse_last = 4'hc;
        endcase
    endfunction
endpackage

// *** tb/lin_node_model.sv ***
// Far-side serial node that drives low runs onto the shared receive line
`timescale 1ns/1ns
module lin_node_model (
    input  wire logic clk_in,
    input  wire logic bit_tick_in,
    input  wire logic break_tx_in,
    output logic      rxd_out
);
    logic drive_q;

    initial drive_q = 1'b1;
    // Open-drain line with pull-up; a device break also pulls it low
    assign rxd_out = drive_q & ~break_tx_in;

    task automatic wait_tick();
        do @(posedge clk_in); while (bit_tick_in !== 1'b1);
    endtask

    task automatic send_low(input int n);
        repeat (3) wait_tick();
        drive_q <= 1'b0;
        repeat (n) wait_tick();
        drive_q <= 1'b1;
        repeat (3) wait_tick();
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the baud divider and break length block
`timescale 1ns/1ns
module tb;
    import baud_lin_pkg::*;
    logic        clk_in    = 1'b0;
    logic        rst_n_in  = 1'b0;
    logic        osc_clk   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic        break_req = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, s_tick, b_tick, brk_tx, brk_done, brk_det, rxd;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    int          det_cnt    = 0;
    int          n, st, c0, ex, k, i;
    logic [31:0] v;
    int          tc[6] = '{0, 1, 2, 3, 0, 0};
    int          tr[6] = '{0, 1, 0, 0, 7, 0};
    int          tf[6] = '{0, 2, 7, 1, 0, 0};
    int          ti[6] = '{5, 0, 31, 1, 0, 0};
    int          ts[6] = '{0, 0, 0, 0, 0, 1};

    always #5 clk_in = ~clk_in;
    // Oscillator at 12.5 MHz, edges on system clock falling edges, away from the rising edges
    always #40 osc_clk = ~osc_clk;

    baud_lin_ctrl baud_lin_ctrl_inst (
        .CLK_IN(clk_in), .RST_N_IN(rst_n_in), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .OSC_CLK_IN(osc_clk), .RXD_IN(rxd),
        .BREAK_REQ_IN(break_req), .SAMPLE_TICK_OUT(s_tick), .BIT_TICK_OUT(b_tick),
        .BREAK_TX_OUT(brk_tx), .BREAK_DONE_OUT(brk_done), .BREAK_DETECT_OUT(brk_det));

    lin_node_model lin_node_model_inst (
        .clk_in(clk_in), .bit_tick_in(b_tick), .break_tx_in(brk_tx), .rxd_out(rxd));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Setup cycle, then access held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err, input logic [31:0] rd);
        @(posedge clk_in);
        exp_q.push_back({err, rd});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reset_values();
        apb(1'b0, OFS_RATE, 32'h0, 1'b0, {24'h0, RATE_RST});
        apb(1'b0, OFS_FINE, 32'h0, 1'b0, {24'h0, FINE_RST});
        apb(1'b0, OFS_CFG, 32'h0, 1'b0, {24'h0, CFG_RST});
    endtask

    task automatic measure();
        do @(posedge clk_in); while (b_tick !== 1'b1);
        n = 0;
        st = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (s_tick === 1'b1) st++;
        end while (b_tick !== 1'b1);
    endtask

    always @(posedge clk_in) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            if (!pwrite) check("prdata", prdata, e[31:0]);
            check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
        end
        if (brk_det === 1'b1) det_cnt++;
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        void'($urandom(83775));
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        reset_values();
        for (i = 0; i < 4; i++) begin
            v = $urandom;
            apb(1'b1, OFS_RATE, v, 1'b0, 32'h0);
            apb(1'b0, OFS_RATE, 32'h0, 1'b0, {24'h0, v[7:0] & RATE_WMASK});
            apb(1'b1, OFS_FINE, v >> 8, 1'b0, 32'h0);
            apb(1'b0, OFS_FINE, 32'h0, 1'b0, {24'h0, v[15:8]});
            // module kept disabled while fine bypass changes
            apb(1'b1, OFS_CFG, v & 32'hfd, 1'b0, 32'h0);
            apb(1'b0, OFS_CFG, 32'h0, 1'b0, {24'h0, v[7:0] & CFG_WMASK & 8'hfd});
        end
        apb(1'b1, 8'h14, 32'hff, 1'b1, 32'h0);
        apb(1'b0, 8'h10, 32'h0, 1'b1, 32'h0);
        for (k = 0; k < 6; k++) begin
            apb(1'b1, OFS_CFG, 32'h0, 1'b0, 32'h0);
            apb(1'b1, OFS_RATE, 32'((tc[k] << 4) | tr[k]), 1'b0, 32'h0);
            apb(1'b1, OFS_FINE, 32'((tf[k] << 5) | ti[k]), 1'b0, 32'h0);
            apb(1'b1, OFS_CFG, 32'(2 | ts[k]), 1'b0, 32'h0);
            ex = (tc[k] == 0) ? 1 : (tc[k] == 1) ? 3 : (tc[k] == 2) ? 4 : 13;
            ex = ex * (1 << tr[k]) * ((tf[k] == 0) ? 64 : 64 * (tf[k] + 1) + 2 * ti[k]);
            ex = ex * ((ts[k] == 1) ? 8 : 1);
            measure();
            measure();
            check("bit period", 32'(n), 32'(ex));
            check("samples per bit", 32'(st), 32'd16);
        end
        for (k = 0; k < 4; k++) begin
            apb(1'b1, OFS_RATE, 32'((k >> 1) << 7), 1'b0, 32'h0);
            apb(1'b1, OFS_CFG, 32'(2 | ((k & 1) << 2)), 1'b0, 32'h0);
            ex = (k == 0) ? 10 : (k == 1) ? 11 : (k == 2) ? 13 : 14;
            @(posedge clk_in);
            break_req <= 1'b1;
            @(posedge clk_in);
            break_req <= 1'b0;
            @(posedge clk_in);
            check("break tx start", {31'h0, brk_tx}, 32'h1);
            n = 0;
            forever begin
                if (b_tick === 1'b1 && (brk_tx === 1'b1 || brk_done === 1'b1)) n++;
                if (brk_done === 1'b1) break;
                @(posedge clk_in);
            end
            check("break tx end", {31'h0, brk_tx}, 32'h0);
            check("break tx bits", 32'(n), 32'(ex));
        end
        for (k = 0; k < 8; k++) begin
            apb(1'b1, OFS_RATE, 32'((k >> 2) << 6), 1'b0, 32'h0);
            apb(1'b1, OFS_CFG, 32'(2 | (((k >> 1) & 1) << 2)), 1'b0, 32'h0);
            ex = 10 + ((k >> 2) & 1) + ((k >> 1) & 1);
            c0 = det_cnt;
            lin_node_model_inst.send_low(ex - 1 + (k & 1));
            check("break detect", 32'(det_cnt - c0), 32'(k & 1));
        end
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check("outputs in reset", {27'h0, s_tick, b_tick, brk_tx, brk_done, brk_det}, 32'h0);
        rst_n_in <= 1'b1;
        reset_values();
        test_done();
    end
endmodule
